// *** hdl/dma_access_qualify.sv ***
// decides whether a bus access counts as a dma transfer for one channel
`timescale 1ns/1ns
`default_nettype none
module dma_access_qualify (
   input  wire dma_req_pkg::chan_cfg_t cfg,
   input  wire dma_req_pkg::bus_in_t   bus,
   output logic                        ackActive,
   output logic                        qualified
);
   import dma_req_pkg::*;

   always_comb begin
      ackActive = cfg.ackPolarity ? bus.dmaAcknowledgeIn : ~bus.dmaAcknowledgeIn;
      qualified = 1'b0;
      if (cfg.channelActivate && bus.accessStrobe) begin
         if (cfg.dmaModeSel) begin
            qualified = bus.dataPortHit;
         end else if (cfg.csMode) begin
            qualified = ackActive && !bus.chipSelectN;
         end else begin
            qualified = ackActive;
         end
      end
   end

endmodule
`default_nettype wire

// *** hdl/dma_req_pkg.sv ***
// shared constants, configuration structs and state types of the dma request channel
package dma_req_pkg;

   localparam int COUNT_W = 32;
   localparam int READY_W = 16;

   localparam int WORD_BYTES  = 2;
   localparam int SINGLE_BYTE = 1;

   localparam logic [COUNT_W-1:0] REMAIN_RST  = 32'h0000_0000;
   localparam logic [READY_W-1:0] SEG_RST     = 16'h0000;
   localparam logic               FLAG_RST    = 1'b0;
   localparam logic [1:0]         BURST_SHIFT = 2'h1;

   // channel configuration, held steady by software while the channel runs
   typedef struct packed {
      logic       channelActivate;
      logic       countMode;
      logic       burstEnable;
      logic [1:0] burstSizeSetting;
      logic       dmaModeSel;
      logic       csMode;
      logic       ackPolarity;
      logic       reqPolarity;
      logic       readDir;
      logic       shortPktHoldDisable;
   } chan_cfg_t;

   // external bus pins as seen by one channel
   typedef struct packed {
      logic accessStrobe;
      logic dmaAcknowledgeIn;
      logic chipSelectN;
      logic dataPortHit;
   } bus_in_t;

   typedef enum logic {CH_IDLE, CH_RUN} chan_state_t;

   // burst setting to bytes: 2, 4, 8 or 16
   function automatic logic [READY_W-1:0] burstBytes(input logic [1:0] setting);
      // widened so that setting 3 plus the shift does not wrap to zero
      burstBytes = READY_W'(1) << (3'(setting) + 3'(BURST_SHIFT));
   endfunction

endpackage

// *** hdl/dma_request_channel.sv ***
// one dma channel: request/acknowledge handshake, count, burst, stop and hold-off
`timescale 1ns/1ns
`default_nettype none
module dma_request_channel #(
   parameter int COUNT_W = dma_req_pkg::COUNT_W,
   parameter int READY_W = dma_req_pkg::READY_W
) (
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   input  wire logic                   clkEn,
   input  wire dma_req_pkg::chan_cfg_t cfg,
   input  wire dma_req_pkg::bus_in_t   bus,
   input  wire logic                   go,
   input  wire logic                   halt,
   input  wire logic                   countLoad,
   input  wire logic [COUNT_W-1:0]     countLoadValue,
   input  wire logic                   doneClear,
   input  wire logic [READY_W-1:0]     fifoReady,
   input  wire logic                   readEnable,
   input  wire logic                   shortPktRx,
   output logic                        dmaRequestOut,
   output logic                        transferAccept,
   output logic [1:0]                  transferBytes,
   output logic                        busy,
   output logic                        channelDoneFlag,
   output logic [COUNT_W-1:0]          transferRemaining,
   output logic                        endpointHoldOffSet
);
   import dma_req_pkg::*;

   if (COUNT_W < 2 || READY_W < 5 || READY_W > COUNT_W) begin : g_bad_width
      $error("dma_request_channel: unsupported COUNT_W or READY_W");
   end

   chan_state_t        state_q;
   chan_state_t        state_d;
   logic [COUNT_W-1:0] remain_q;
   logic [COUNT_W-1:0] remain_d;
   logic [READY_W-1:0] segLeft_q;
   logic [READY_W-1:0] segLeft_d;
   logic               done_q;
   logic               holdOff_q;

   logic               ackActive;
   logic               qualified;
   logic               reqOk;
   logic [READY_W-1:0] grantQty;
   logic               running;
   logic               accept;
   logic [1:0]         bytesNow;
   logic               lastAccess;
   logic               segEnd;
   logic               reqRaw;
   logic               reqActive;
   logic               stopEvent;

   dma_access_qualify u_qualify (
      .cfg       (cfg),
      .bus       (bus),
      .ackActive (ackActive),
      .qualified (qualified)
   );

   dma_request_gate #(
      .CW (COUNT_W),
      .RW (READY_W)
   ) u_gate (
      .cfg        (cfg),
      .fifoReady  (fifoReady),
      .readEnable (readEnable),
      .remaining  (remain_q),
      .reqOk      (reqOk),
      .grantQty   (grantQty)
   );

   // one accepted access per cycle while running
   always_comb begin
      running  = state_q == CH_RUN;
      accept   = running && qualified && !halt;
      bytesNow = (cfg.countMode && remain_q == COUNT_W'(SINGLE_BYTE)) ?
                 2'(SINGLE_BYTE) : 2'(WORD_BYTES);
      lastAccess = accept && cfg.countMode && remain_q <= COUNT_W'(bytesNow);
      segEnd     = accept && cfg.burstEnable && segLeft_q <= READY_W'(bytesNow);
   end

   // request: live fifo condition, or a latched burst segment
   always_comb begin
      if (cfg.burstEnable) begin
         reqRaw = running && segLeft_q != '0;
      end else begin
         reqRaw = running && reqOk;
      end
      reqActive = reqRaw && !lastAccess && !segEnd && !halt;
      dmaRequestOut = cfg.reqPolarity ? reqActive : !reqActive;
   end

   always_comb begin
      stopEvent = running && (halt || lastAccess);
      state_d   = state_q;
      case (state_q)
         CH_IDLE: begin
            if (go && !halt) begin
               state_d = CH_RUN;
            end
         end
         CH_RUN: begin
            if (halt) begin
               state_d = CH_IDLE;
            end else if (lastAccess) begin
               state_d = CH_IDLE;
            end
         end
         default: state_d = CH_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= CH_IDLE;
      end else if (clkEn) begin
         state_q <= state_d;
      end
   end

   always_comb begin
      remain_d = remain_q;
      if (!running && countLoad) begin
         remain_d = countLoadValue;
      end else if (accept && cfg.countMode) begin
         if (remain_q > COUNT_W'(bytesNow)) begin
            remain_d = remain_q - COUNT_W'(bytesNow);
         end else begin
            remain_d = '0;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         remain_q <= REMAIN_RST;
      end else if (clkEn) begin
         remain_q <= remain_d;
      end
   end

   // burst segment: load the guaranteed quantity, count it down per access
   always_comb begin
      segLeft_d = segLeft_q;
      if (!running || halt || !cfg.burstEnable) begin
         segLeft_d = '0;
      end else if (segLeft_q == '0) begin
         if (reqOk) begin
            segLeft_d = grantQty;
         end
      end else if (segEnd || lastAccess) begin
         segLeft_d = '0;
      end else if (accept) begin
         segLeft_d = segLeft_q - READY_W'(bytesNow);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         segLeft_q <= SEG_RST;
      end else if (clkEn) begin
         segLeft_q <= segLeft_d;
      end
   end

   // done flag: a stop in the clearing cycle still sets it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         done_q <= FLAG_RST;
      end else if (clkEn) begin
         if (stopEvent) begin
            done_q <= 1'b1;
         end else if (doneClear) begin
            done_q <= 1'b0;
         end
      end
   end

   // hold-off request toward the endpoint, set one cycle after either cause and held while it lasts
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         holdOff_q <= FLAG_RST;
      end else if (clkEn) begin
         holdOff_q <= (running && cfg.countMode && cfg.readDir &&
                       COUNT_W'(fifoReady) > remain_q)
                      || (shortPktRx && !cfg.shortPktHoldDisable);
      end
   end

   always_comb begin
      transferAccept     = accept;
      transferBytes      = accept ? bytesNow : 2'h0;
      busy               = running;
      channelDoneFlag    = done_q;
      transferRemaining  = remain_q;
      endpointHoldOffSet = holdOff_q;
   end

   a_cs_qualify: assert property (@(posedge clk) disable iff (!arst_n)
      (cfg.csMode && !cfg.dmaModeSel && qualified) |-> (!bus.chipSelectN && ackActive))
      else $error("select-qualified access without chip select or acknowledge");

   a_port_qualify: assert property (@(posedge clk) disable iff (!arst_n)
      (cfg.dmaModeSel && cfg.channelActivate && bus.accessStrobe && bus.dataPortHit)
      |-> qualified)
      else $error("data port access not taken as dma");

   a_zero_count: assert property (@(posedge clk) disable iff (!arst_n)
      (cfg.countMode && remain_q == '0) |-> !reqActive)
      else $error("request with no count remaining");

   a_free_run: assert property (@(posedge clk) disable iff (!arst_n)
      (running && !cfg.countMode && !cfg.burstEnable && !halt && !accept
       && fifoReady >= READY_W'(WORD_BYTES) && (!cfg.readDir || readEnable)) |-> reqActive)
      else $error("free-run request missing with fifo quantity");

   a_burst_guard: assert property (@(posedge clk) disable iff (!arst_n)
      (clkEn && running && cfg.burstEnable && segLeft_q == '0 && segLeft_d != '0)
      |-> ((fifoReady >= burstBytes(cfg.burstSizeSetting)
            || (cfg.countMode && COUNT_W'(fifoReady) >= remain_q))
           ##1 (reqActive || halt || !clkEn)))
      else $error("burst segment opened without enough fifo bytes");

   a_burst_remain: assert property (@(posedge clk) disable iff (!arst_n)
      (clkEn && running && cfg.burstEnable && cfg.countMode && segLeft_q == '0
       && segLeft_d != '0 && remain_q < COUNT_W'(burstBytes(cfg.burstSizeSetting)))
      |=> segLeft_q == READY_W'($past(remain_q)))
      else $error("short burst segment not sized to remaining count");

   a_byte_single: assert property (@(posedge clk) disable iff (!arst_n)
      (accept && bytesNow == 2'(SINGLE_BYTE)) |-> (cfg.countMode && remain_q == 1))
      else $error("single-byte access outside final count");

   a_req_level: assert property (@(posedge clk) disable iff (!arst_n)
      dmaRequestOut == (cfg.reqPolarity ? reqActive : !reqActive))
      else $error("request pin polarity wrong");

   a_go_busy: assert property (@(posedge clk) disable iff (!arst_n)
      (clkEn && !running && go && !halt) |=> busy)
      else $error("go did not start the channel");

   a_last_drop: assert property (@(posedge clk) disable iff (!arst_n)
      lastAccess |-> (!reqActive ##1 (!busy || !$past(clkEn))))
      else $error("request or busy kept after final access");

   a_halt_stop: assert property (@(posedge clk) disable iff (!arst_n)
      (halt && clkEn) |-> (!reqActive ##1 (!busy && !reqActive)))
      else $error("halt did not stop the channel");

   a_done_set: assert property (@(posedge clk) disable iff (!arst_n)
      (stopEvent && clkEn) |=> channelDoneFlag)
      else $error("stop did not set the done flag");

   a_fifo_empty: assert property (@(posedge clk) disable iff (!arst_n)
      (!cfg.burstEnable && fifoReady == '0) |-> !reqActive)
      else $error("request with empty fifo quantity");

   a_hold_excess: assert property (@(posedge clk) disable iff (!arst_n)
      (clkEn && running && cfg.countMode && cfg.readDir
       && COUNT_W'(fifoReady) > remain_q) |=> endpointHoldOffSet)
      else $error("excess read data did not set hold-off");

   a_hold_short: assert property (@(posedge clk) disable iff (!arst_n)
      (clkEn && shortPktRx && !cfg.shortPktHoldDisable) |=> endpointHoldOffSet)
      else $error("short packet did not set hold-off");

   a_count_dec: assert property (@(posedge clk) disable iff (!arst_n)
      (clkEn && accept && cfg.countMode && remain_q > COUNT_W'(bytesNow))
      |=> transferRemaining == $past(remain_q) - COUNT_W'($past(bytesNow)))
      else $error("remaining count not reduced by bytes moved");

   a_read_gate: assert property (@(posedge clk) disable iff (!arst_n)
      (cfg.readDir && !readEnable && !cfg.burstEnable) |-> !reqActive)
      else $error("read request without read enable");

   a_one_left: assert property (@(posedge clk) disable iff (!arst_n)
      (running && cfg.countMode && !cfg.burstEnable && !cfg.readDir && !halt && !accept
       && remain_q == COUNT_W'(SINGLE_BYTE) && fifoReady != '0) |-> reqActive)
      else $error("one free byte with one count left did not request");

   a_two_needed: assert property (@(posedge clk) disable iff (!arst_n)
      (cfg.countMode && !cfg.burstEnable && remain_q > COUNT_W'(SINGLE_BYTE)
       && fifoReady < READY_W'(WORD_BYTES)) |-> !reqActive)
      else $error("request with one free byte and counts left");

endmodule
`default_nettype wire

// *** hdl/dma_request_gate.sv ***
// request condition and permitted transfer quantity from fifo level and remaining count
`timescale 1ns/1ns
`default_nettype none
module dma_request_gate #(
   parameter int CW = dma_req_pkg::COUNT_W,
   parameter int RW = dma_req_pkg::READY_W
) (
   input  wire dma_req_pkg::chan_cfg_t cfg,
   input  wire logic [RW-1:0]          fifoReady,
   input  wire logic                   readEnable,
   input  wire logic [CW-1:0]          remaining,
   output logic                        reqOk,
   output logic [RW-1:0]               grantQty
);
   import dma_req_pkg::*;

   if (CW < 2 || RW < 5) begin : g_bad_width
      $error("dma_request_gate: unsupported CW or RW");
   end

   localparam int MW = (CW > RW) ? CW : RW;

   logic [MW-1:0] rdyX;
   logic [MW-1:0] remX;
   logic [MW-1:0] reqX;
   logic [MW-1:0] evenX;

   always_comb begin
      rdyX  = MW'(fifoReady);
      remX  = MW'(remaining);
      reqX  = MW'(burstBytes(cfg.burstSizeSetting));
      evenX = {rdyX[MW-1:1], 1'b0};
      reqOk    = 1'b0;
      grantQty = '0;
      if (cfg.burstEnable) begin
         if (cfg.countMode && remX < reqX) begin
            reqOk    = (remX != '0) && (rdyX >= remX);
            grantQty = RW'(remX);
         end else begin
            reqOk    = rdyX >= reqX;
            grantQty = RW'(reqX);
         end
      end else if (cfg.countMode) begin
         if (remX == MW'(SINGLE_BYTE)) begin
            reqOk    = rdyX != '0;
            grantQty = RW'(SINGLE_BYTE);
         end else begin
            reqOk    = (remX != '0) && (rdyX >= MW'(WORD_BYTES));
            grantQty = (remX < evenX) ? RW'(remX) : RW'(evenX);
         end
      end else begin
         reqOk    = rdyX >= MW'(WORD_BYTES);
         grantQty = RW'(evenX);
      end
      if (cfg.countMode && remX == '0) begin
         reqOk = 1'b0;
      end
      if (cfg.readDir && !readEnable) begin
         reqOk = 1'b0;
      end
   end

endmodule
`default_nettype wire

// *** sim/dma_master_model.sv ***
// behavioural model of the external cpu dma master that answers the request pin
`timescale 1ns/1ns
`default_nettype none
module dma_master_model (
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   input  wire logic                 run,
   input  wire logic                 slow,
   input  wire logic                 csHigh,
   input  wire logic                 ackPolarity,
   input  wire logic                 reqPolarity,
   input  wire logic                 reqPin,
   output var  dma_req_pkg::bus_in_t bus
);
   import dma_req_pkg::*;

   logic gapQ;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bus  <= '{1'b0, !ackPolarity, 1'b1, 1'b0};
         gapQ <= 1'b0;
      end else begin
         // slow master leaves an idle cycle after every access
         gapQ <= slow & run & ~gapQ;
         if (run && (reqPin == reqPolarity) && !gapQ) begin
            bus.accessStrobe     <= 1'b1;
            bus.dmaAcknowledgeIn <= ackPolarity;
            bus.chipSelectN      <= csHigh;
            bus.dataPortHit      <= 1'b1;
         end else begin
            bus <= '{1'b0, !ackPolarity, 1'b1, 1'b0};
         end
      end
   end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for one dma request channel against a master model
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin \
   nCompared++; \
   if ((got) !== (exp)) begin \
      badCount++; \
      $display("Error %s expected %0h seen %0h", nm, exp, got); \
   end \
end
module tb_top;
   import dma_req_pkg::*;

   logic            clk, arst_n, clkEn, go, halt, countLoad, doneClear;
   logic            readEnable, shortPktRx, mRun, mSlow, mCsHigh, mAckPol;
   logic            dmaRequestOut, transferAccept, busy, channelDoneFlag, endpointHoldOffSet;
   logic [1:0]      transferBytes;
   logic [31:0]     countLoadValue, transferRemaining;
   logic [15:0]     fifoReady;
   chan_cfg_t       cfg, c;
   bus_in_t         bus;
   int              badCount, nCompared, sum, ones, cycles;
   logic            hoSeen;

   dma_request_channel dut (.clk(clk), .arst_n(arst_n), .clkEn(clkEn), .cfg(cfg), .bus(bus),
      .go(go), .halt(halt), .countLoad(countLoad), .countLoadValue(countLoadValue),
      .doneClear(doneClear), .fifoReady(fifoReady), .readEnable(readEnable),
      .shortPktRx(shortPktRx), .dmaRequestOut(dmaRequestOut), .transferAccept(transferAccept),
      .transferBytes(transferBytes), .busy(busy), .channelDoneFlag(channelDoneFlag),
      .transferRemaining(transferRemaining), .endpointHoldOffSet(endpointHoldOffSet));

   dma_master_model master (.clk(clk), .arst_n(arst_n), .run(mRun), .slow(mSlow),
      .csHigh(mCsHigh), .ackPolarity(mAckPol), .reqPolarity(cfg.reqPolarity),
      .reqPin(dmaRequestOut), .bus(bus));

   function automatic chan_cfg_t mkCfg(input logic cnt, input logic bst, input logic [1:0] bsz,
                                       input logic sel, input logic csm, input logic ackP,
                                       input logic reqP, input logic rd);
      mkCfg = '{1'b1, cnt, bst, bsz, sel, csm, ackP, reqP, rd, 1'b0};
   endfunction

   task automatic completeRun;
      $display("compared %0d mismatches %0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chkReq(input string nm, input logic act);
      `CHK(nm, act ? cfg.reqPolarity : !cfg.reqPolarity, dmaRequestOut)
   endtask

   // count is loaded before go
   task automatic start(input chan_cfg_t cf, input logic [31:0] n, input logic [15:0] rdy);
      @(posedge clk);
      cfg <= cf;
      fifoReady <= rdy;
      countLoad <= 1'b1;
      countLoadValue <= n;
      @(posedge clk);
      countLoad <= 1'b0;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      #1;
   endtask

   task automatic clearDone;
      @(posedge clk) doneClear <= 1'b1;
      @(posedge clk) doneClear <= 1'b0;
      tick(1);
      `CHK("done cleared", 1'b0, channelDoneFlag)
   endtask

   task automatic runTo(input string nm, input int expSum);
      int k;
      sum = 0;
      k = 0;
      @(posedge clk) mRun <= 1'b1;
      tick(1);
      while (busy !== 1'b0 && k < 300) begin
         tick(1);
         k++;
      end
      @(posedge clk) mRun <= 1'b0;
      tick(1);
      `CHK("bytes moved", expSum, sum)
      `CHK("remaining at end", 32'h0, transferRemaining)
      `CHK("busy at end", 1'b0, busy)
      `CHK("done at end", 1'b1, channelDoneFlag)
      clearDone();
      $display("test %s done", nm);
   endtask

   task automatic stopChan(input logic withDone);
      @(posedge clk) mRun <= 1'b0; // master stopped before halt
      tick(2);
      @(posedge clk) halt <= 1'b1;
      @(posedge clk) halt <= 1'b0;
      #1;
      `CHK("busy after halt", 1'b0, busy)
      chkReq("request after halt", 1'b0);
      tick(1);
      if (withDone) `CHK("done after halt", 1'b1, channelDoneFlag)
      clearDone();
   endtask

   always @(posedge clk) begin
      cycles++;
      if (transferAccept === 1'b1) begin
         sum += transferBytes;
         if (transferBytes === 2'h1) ones++;
         if (cfg.countMode && transferRemaining == 32'(transferBytes))
            chkReq("request on final access", 1'b0);
      end
      if (endpointHoldOffSet === 1'b1) hoSeen = 1'b1;
      if (cycles == 20000) begin
         badCount++;
         completeRun();
      end
   end

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      arst_n = 1'b0; clkEn = 1'b1; go = 1'b0; halt = 1'b0; countLoad = 1'b0; doneClear = 1'b0;
      readEnable = 1'b0; shortPktRx = 1'b0; mRun = 1'b0; mSlow = 1'b0; mCsHigh = 1'b0;
      mAckPol = 1'b0; countLoadValue = 32'h0; fifoReady = 16'h0000; hoSeen = 1'b0;
      cfg = mkCfg(1'b1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      tick(1);
      `CHK("busy after reset", 1'b0, busy)
      `CHK("done after reset", 1'b0, channelDoneFlag)
      `CHK("remaining after reset", 32'h0, transferRemaining)
      chkReq("request after reset", 1'b0);
      // acknowledge plus chip select, fifo empty first
      start(mkCfg(1'b1, 1'b0, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0), 32'h6, 16'h0000);
      tick(2);
      chkReq("request fifo empty", 1'b0);
      @(posedge clk) fifoReady <= 16'h0010;
      tick(1);
      chkReq("request fifo refilled", 1'b1);
      @(posedge clk) mCsHigh <= 1'b1;
      mRun <= 1'b1;
      tick(6);
      `CHK("remaining without select", 32'h6, transferRemaining)
      @(posedge clk) mCsHigh <= 1'b0;
      runTo("select qualified", 6);
      // a count load while the clock enable is low must be ignored
      @(posedge clk) clkEn <= 1'b0;
      countLoad <= 1'b1;
      countLoadValue <= 32'h9;
      @(posedge clk) countLoad <= 1'b0;
      clkEn <= 1'b1;
      tick(1);
      `CHK("remaining while frozen", 32'h0, transferRemaining)
      // odd count ends with one byte
      start(mkCfg(1'b1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0), 32'h5, 16'h0001);
      tick(2);
      chkReq("request one free byte", 1'b0);
      @(posedge clk) fifoReady <= 16'h0010;
      ones = 0;
      runTo("odd count", 5);
      `CHK("single byte accesses", 1, ones)
      @(posedge clk) fifoReady <= 16'h0000; // fifo cleared after odd-length transfer
      start(mkCfg(1'b1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0), 32'h1, 16'h0001);
      tick(2);
      chkReq("request last byte", 1'b1);
      runTo("single byte", 1);
      // active high pins with a slow master
      @(posedge clk) mAckPol <= 1'b1;
      mSlow <= 1'b1;
      start(mkCfg(1'b1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0), 32'h8, 16'h0010);
      tick(2);
      chkReq("request active high", 1'b1);
      runTo("active high", 8);
      // data port window ignores the acknowledge level
      @(posedge clk) mSlow <= 1'b0;
      start(mkCfg(1'b1, 1'b0, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0), 32'h4, 16'h0010);
      runTo("data port", 4);
      @(posedge clk) mAckPol <= 1'b0;
      c = mkCfg(1'b1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      c.channelActivate = 1'b0;
      start(c, 32'h4, 16'h0010);
      sum = 0;
      @(posedge clk) mRun <= 1'b1;
      tick(6);
      `CHK("bytes while inactive", 0, sum)
      stopChan(1'b1);
      // burst of four bytes
      start(mkCfg(1'b1, 1'b1, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0), 32'h10, 16'h0002);
      tick(3);
      chkReq("burst below setting", 1'b0);
      @(posedge clk) fifoReady <= 16'h0008;
      tick(2);
      chkReq("burst reached", 1'b1);
      runTo("burst", 16);
      start(mkCfg(1'b1, 1'b1, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0), 32'h2, 16'h0004);
      tick(2);
      chkReq("burst covers remaining", 1'b1);
      runTo("burst remaining", 2);
      // count read, fifo holds more than the count
      hoSeen = 1'b0;
      start(mkCfg(1'b1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1), 32'h4, 16'h0008);
      tick(2);
      chkReq("read not enabled", 1'b0);
      @(posedge clk) readEnable <= 1'b1;
      tick(2);
      chkReq("read enabled", 1'b1);
      `CHK("hold-off on excess data", 1'b1, hoSeen)
      stopChan(1'b1);
      for (int d = 0; d < 2; d++) begin
         c = cfg;
         c.shortPktHoldDisable = d[0];
         @(posedge clk) cfg <= c;
         tick(2);
         hoSeen = 1'b0;
         @(posedge clk) shortPktRx <= 1'b1;
         @(posedge clk) shortPktRx <= 1'b0;
         tick(2);
         `CHK("short packet hold-off", !d[0], hoSeen)
      end
      $display("test read hold-off done");
      // free run keeps requesting without a count
      @(posedge clk) readEnable <= 1'b0;
      start(mkCfg(1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0), 32'h0, 16'h0001);
      tick(2);
      chkReq("free run one byte", 1'b0);
      @(posedge clk) fifoReady <= 16'h0010;
      mRun <= 1'b1;
      tick(20);
      chkReq("free run streaming", 1'b1);
      `CHK("free run busy", 1'b1, busy)
      `CHK("free run count", 32'h0, transferRemaining)
      stopChan(1'b1);
      $display("test free run done");
      completeRun();
   end
endmodule
`default_nettype wire
